// [pkg/sp_cap_pkg.sv]
// constants shared by the single-pulse / capture timer block
package sp_cap_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFFS   = 8'h00;
	localparam logic [7:0] STATUS_OFFS = 8'h04;
	localparam logic [7:0] CMPA_OFFS   = 8'h08;
	localparam logic [7:0] CMPB_OFFS   = 8'h0C;
	localparam logic [7:0] PERIOD_OFFS = 8'h10;
	localparam logic [7:0] COUNT_OFFS  = 8'h14;
	// control field positions
	localparam int MODE_LSB  = 0;
	localparam int IO_LSB    = 2;
	localparam int RUN_BIT   = 4;
	localparam int CAPTS_BIT = 5;
	localparam int TCLR_LSB  = 6;
	localparam int CCLR_BIT  = 8;
	localparam int OC_BIT    = 9;
	localparam int POL_BIT   = 10;
	// status field positions
	localparam int MAF_BIT = 0;
	localparam int PMF_BIT = 1;
	// reset values
	localparam logic [1:0]  FIELD2_RST = 2'h0;
	localparam logic [31:0] WORD_RST   = 32'h0;
	// modes and field encodings
	localparam logic [1:0] MODE_CAPTURE = 2'h1;
	localparam logic [1:0] MODE_SINGLE  = 2'h2;
	localparam logic [1:0] IO_RISE      = 2'h0;
	localparam logic [1:0] IO_FALL      = 2'h1;
	localparam logic [1:0] IO_BOTH      = 2'h2;
	localparam logic [1:0] IO_NONE      = 2'h3;
	localparam logic [1:0] TCLR_NONE    = 2'h0;
	localparam logic [1:0] TCLR_RISE    = 2'h1;
	localparam logic [1:0] TCLR_FALL    = 2'h2;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;
	// timing, in tenths of a timer clock period (timer clock = CLK)
	localparam int FLAG_DELAY_TENTHS = 5;
	localparam int LATCH_MAX_TENTHS  = 15;
	localparam int FLAG_DELAY_CYC    = (FLAG_DELAY_TENTHS + 9) / 10;
	localparam int LATCH_MAX_CYC     = LATCH_MAX_TENTHS / 10;
	// run phase of the counter
	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_RUN  = 2'h1,
		PH_HELD = 2'h3
	} phase_t;
endpackage

// [rtl/pin_sync.sv]
// three-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 2
) (
	input  wire logic         CLK,
	input  wire logic         SRST,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] stage2,
	output logic      [W-1:0] stage3
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} sync_t;
	sync_t s_ff, nxt_s;

	if (W < 1) begin : g_chk
		$error("pin_sync width must be at least one");
	end

	always_comb begin
		nxt_s    = s_ff;
		nxt_s.s1 = pin_in;
		nxt_s.s2 = s_ff.s1;
		nxt_s.s3 = s_ff.s2;
		if (SRST) begin
			nxt_s = '0;
		end
	end

	always_ff @(posedge CLK) begin
		s_ff <= nxt_s;
	end

	assign stage2 = s_ff.s2;
	assign stage3 = s_ff.s3;
endmodule

// [rtl/sp_cap_timer.sv]
// single-pulse output and capture input timer with AXI4-Lite registers
`timescale 1ns/100ps
module sp_cap_timer #(
	parameter int CNT_W = 16
) (
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	input  wire logic        EXT_CLOCK_PIN,
	input  wire logic        CAPTURE_PIN,
	output logic             PULSE_OUT,
	output logic             PULSE_OE_N
);
	typedef struct packed {
		logic                 awready;
		logic                 wready;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 arready;
		logic                 rvalid;
		logic [1:0]           rresp;
		logic [31:0]          rdata;
		logic                 aw_full;
		logic                 w_full;
		logic [7:0]           awaddr;
		logic [31:0]          wdata;
		logic [3:0]           wstrb;
		logic [1:0]           mode_select;
		logic [1:0]           io_select;
		logic [1:0]           capture_clear_sel;
		logic                 capture_source_sel;
		logic                 counter_clear_sel;
		logic                 output_initial_level;
		logic                 output_polarity;
		sp_cap_pkg::phase_t   phase;
		logic [CNT_W-1:0]     cnt;
		logic [CNT_W-1:0]     compare_a_value;
		logic [CNT_W-1:0]     compare_b_value;
		logic [CNT_W-1:0]     period_value;
		logic                 match_a_flag;
		logic                 period_match_flag;
		logic                 cap_pend;
		logic                 pulse;
		logic                 oe_n;
		logic                 pin;
		logic [1:0]           pin_lvl;
	} st_t;
	st_t s_ff, nxt_s;

	if (CNT_W < 2 || CNT_W > 32) begin : g_chk
		$error("counter width must lie between 2 and 32");
	end

	logic [1:0]       sync2;
	logic [1:0]       sync3;
	logic [1:0]       pin_rise;
	logic [1:0]       pin_fall;
	logic             ext_rise;
	logic             src_rise;
	logic             src_fall;
	logic             run_now;
	logic             sp_mode;
	logic             cp_mode;
	logic             do_wr;
	logic [31:0]      wr_val;
	logic             new_run;
	logic             start;
	logic             match_a;
	logic             cap_fire;
	logic             clr_edge;
	logic             per_hit;
	logic [CNT_W-1:0] cnt_inc;

	// bit 1: external clock pin, bit 0: capture pin
	pin_sync #(.W(2)) u_sync (
		.CLK    (CLK),
		.SRST   (SRST),
		.pin_in ({EXT_CLOCK_PIN, CAPTURE_PIN}),
		.stage2 (sync2),
		.stage3 (sync3)
	);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] rd_word(input st_t s, input logic [7:0] a, input logic run);
		logic [31:0] r;
		r = sp_cap_pkg::WORD_RST;
		case (a)
			sp_cap_pkg::CTRL_OFFS: begin
				r[sp_cap_pkg::MODE_LSB +: 2] = s.mode_select;
				r[sp_cap_pkg::IO_LSB +: 2]   = s.io_select;
				r[sp_cap_pkg::RUN_BIT]       = run;
				r[sp_cap_pkg::CAPTS_BIT]     = s.capture_source_sel;
				r[sp_cap_pkg::TCLR_LSB +: 2] = s.capture_clear_sel;
				r[sp_cap_pkg::CCLR_BIT]      = s.counter_clear_sel;
				r[sp_cap_pkg::OC_BIT]        = s.output_initial_level;
				r[sp_cap_pkg::POL_BIT]       = s.output_polarity;
			end
			sp_cap_pkg::STATUS_OFFS: begin
				r[sp_cap_pkg::MAF_BIT] = s.match_a_flag;
				r[sp_cap_pkg::PMF_BIT] = s.period_match_flag;
			end
			sp_cap_pkg::CMPA_OFFS:   r[CNT_W-1:0] = s.compare_a_value;
			sp_cap_pkg::CMPB_OFFS:   r[CNT_W-1:0] = s.compare_b_value;
			sp_cap_pkg::PERIOD_OFFS: r[CNT_W-1:0] = s.period_value;
			sp_cap_pkg::COUNT_OFFS:  r[CNT_W-1:0] = s.cnt;
			default:                 r = sp_cap_pkg::WORD_RST;
		endcase
		return r;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a == sp_cap_pkg::CTRL_OFFS || a == sp_cap_pkg::STATUS_OFFS ||
			a == sp_cap_pkg::CMPA_OFFS || a == sp_cap_pkg::CMPB_OFFS ||
			a == sp_cap_pkg::PERIOD_OFFS || a == sp_cap_pkg::COUNT_OFFS;
	endfunction

	always_comb begin
		nxt_s    = s_ff;
		run_now  = s_ff.phase == sp_cap_pkg::PH_RUN;
		sp_mode  = s_ff.mode_select == sp_cap_pkg::MODE_SINGLE;
		cp_mode  = s_ff.mode_select == sp_cap_pkg::MODE_CAPTURE;
		// an edge counts once stages two and three agree on the new level
		pin_rise      = sync2 & sync3 & ~s_ff.pin_lvl;
		pin_fall      = ~(sync2 | sync3) & s_ff.pin_lvl;
		nxt_s.pin_lvl = (s_ff.pin_lvl | pin_rise) & ~pin_fall;
		ext_rise      = pin_rise[1];
		// source select
		src_rise = s_ff.capture_source_sel ? pin_rise[1] : pin_rise[0];
		src_fall = s_ff.capture_source_sel ? pin_fall[1] : pin_fall[0];
		do_wr    = s_ff.aw_full & s_ff.w_full & ~s_ff.bvalid;
		wr_val   = merge(rd_word(s_ff, s_ff.awaddr, run_now), s_ff.wdata, s_ff.wstrb);
		new_run  = wr_val[sp_cap_pkg::RUN_BIT];
		cnt_inc  = s_ff.cnt + CNT_W'(1);

		// write channel
		if (s_ff.bvalid & BREADY) begin
			nxt_s.bvalid = 1'b0;
		end
		if (AWVALID & s_ff.awready) begin
			nxt_s.aw_full = 1'b1;
			nxt_s.awaddr  = AWADDR;
		end
		if (WVALID & s_ff.wready) begin
			nxt_s.w_full = 1'b1;
			nxt_s.wdata  = WDATA;
			nxt_s.wstrb  = WSTRB;
		end
		if (do_wr) begin
			nxt_s.aw_full = 1'b0;
			nxt_s.w_full  = 1'b0;
			nxt_s.bvalid  = 1'b1;
			nxt_s.bresp   = mapped(s_ff.awaddr) ? sp_cap_pkg::RESP_OKAY : sp_cap_pkg::RESP_SLVERR;
			case (s_ff.awaddr)
				sp_cap_pkg::CTRL_OFFS: begin
					nxt_s.mode_select          = wr_val[sp_cap_pkg::MODE_LSB +: 2];
					nxt_s.io_select            = wr_val[sp_cap_pkg::IO_LSB +: 2];
					nxt_s.capture_source_sel   = wr_val[sp_cap_pkg::CAPTS_BIT];
					nxt_s.capture_clear_sel    = wr_val[sp_cap_pkg::TCLR_LSB +: 2];
					nxt_s.counter_clear_sel    = wr_val[sp_cap_pkg::CCLR_BIT];
					nxt_s.output_initial_level = wr_val[sp_cap_pkg::OC_BIT];
					nxt_s.output_polarity      = wr_val[sp_cap_pkg::POL_BIT];
				end
				sp_cap_pkg::STATUS_OFFS: begin
					// write one to clear; a set below wins
					if (s_ff.wstrb[0] & s_ff.wdata[sp_cap_pkg::MAF_BIT]) begin
						nxt_s.match_a_flag = 1'b0;
					end
					if (s_ff.wstrb[0] & s_ff.wdata[sp_cap_pkg::PMF_BIT]) begin
						nxt_s.period_match_flag = 1'b0;
					end
				end
				sp_cap_pkg::CMPA_OFFS:   nxt_s.compare_a_value = wr_val[CNT_W-1:0];
				sp_cap_pkg::CMPB_OFFS:   nxt_s.compare_b_value = wr_val[CNT_W-1:0];
				sp_cap_pkg::PERIOD_OFFS: nxt_s.period_value = wr_val[CNT_W-1:0];
				default:                 nxt_s.bresp = nxt_s.bresp;
			endcase
		end
		nxt_s.awready = ~nxt_s.aw_full & ~nxt_s.bvalid;
		nxt_s.wready  = ~nxt_s.w_full & ~nxt_s.bvalid;

		// read channel
		if (s_ff.rvalid & RREADY) begin
			nxt_s.rvalid  = 1'b0;
			nxt_s.arready = 1'b1;
		end
		if (ARVALID & s_ff.arready) begin
			nxt_s.rvalid  = 1'b1;
			nxt_s.arready = 1'b0;
			nxt_s.rdata   = rd_word(s_ff, ARADDR, run_now);
			nxt_s.rresp   = mapped(ARADDR) ? sp_cap_pkg::RESP_OKAY : sp_cap_pkg::RESP_SLVERR;
		end

		// run control
		start   = ~run_now & ((do_wr & s_ff.awaddr == sp_cap_pkg::CTRL_OFFS & new_run) |
			(sp_mode & ext_rise));
		match_a = sp_mode & run_now & s_ff.cnt == s_ff.compare_a_value;
		per_hit = (s_ff.period_value == '0) ? (s_ff.cnt == '1) : (s_ff.cnt == s_ff.period_value);
		case (s_ff.capture_clear_sel)
			sp_cap_pkg::TCLR_NONE: clr_edge = 1'b0;
			sp_cap_pkg::TCLR_RISE: clr_edge = src_rise;
			sp_cap_pkg::TCLR_FALL: clr_edge = src_fall;
			default:               clr_edge = src_rise | src_fall;
		endcase
		case (s_ff.io_select)
			sp_cap_pkg::IO_RISE: cap_fire = src_rise;
			sp_cap_pkg::IO_FALL: cap_fire = src_fall;
			sp_cap_pkg::IO_BOTH: cap_fire = src_rise | src_fall;
			default:             cap_fire = 1'b0;
		endcase
		cap_fire = cap_fire & cp_mode & run_now;

		nxt_s.cap_pend = cap_fire;
		if (s_ff.cap_pend) begin
			nxt_s.match_a_flag = 1'b1;
		end
		if (start) begin
			nxt_s.phase = sp_cap_pkg::PH_RUN;
			nxt_s.cnt   = '0;
			nxt_s.pulse = 1'b1;
		end else if (run_now) begin
			if (match_a | (do_wr & s_ff.awaddr == sp_cap_pkg::CTRL_OFFS & ~new_run)) begin
				nxt_s.phase = sp_cap_pkg::PH_HELD;
				nxt_s.pulse = 1'b0;
				if (match_a) begin
					nxt_s.match_a_flag = 1'b1;
				end
			end else if (sp_mode) begin
				nxt_s.cnt = cnt_inc;
			end else if (cp_mode) begin
				if (per_hit | clr_edge) begin
					nxt_s.cnt = '0;
				end else begin
					nxt_s.cnt = cnt_inc;
				end
				if (per_hit) begin
					nxt_s.period_match_flag = 1'b1;
				end
			end
		end
		if (cap_fire) begin
			// clearing edges land in B, the rest in A
			if (s_ff.capture_clear_sel != sp_cap_pkg::TCLR_NONE && clr_edge) begin
				nxt_s.compare_b_value = s_ff.cnt;
			end else begin
				nxt_s.compare_a_value = s_ff.cnt;
			end
		end

		// output pin, driven only in single pulse
		nxt_s.oe_n = nxt_s.mode_select != sp_cap_pkg::MODE_SINGLE;
		nxt_s.pin  = nxt_s.oe_n ? 1'b0 :
			((nxt_s.pulse ? nxt_s.output_initial_level : ~nxt_s.output_initial_level) ^
			nxt_s.output_polarity);

		if (SRST) begin
			nxt_s         = '0;
			nxt_s.phase   = sp_cap_pkg::PH_IDLE;
			nxt_s.awready = 1'b1;
			nxt_s.wready  = 1'b1;
			nxt_s.arready = 1'b1;
			nxt_s.oe_n    = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		s_ff <= nxt_s;
	end

	assign AWREADY    = s_ff.awready;
	assign WREADY     = s_ff.wready;
	assign BVALID     = s_ff.bvalid;
	assign BRESP      = s_ff.bresp;
	assign ARREADY    = s_ff.arready;
	assign RVALID     = s_ff.rvalid;
	assign RDATA      = s_ff.rdata;
	assign RRESP      = s_ff.rresp;
	assign PULSE_OUT  = s_ff.pin;
	assign PULSE_OE_N = s_ff.oe_n;

	property p_start_count;
		@(posedge CLK) disable iff (SRST)
		start |=> run_now && s_ff.cnt == '0 ##1 (s_ff.cnt == CNT_W'(1) || !run_now);
	endproperty
	a_start_count: assert property (p_start_count) else $error("run start did not restart count");

	property p_ext_trigger;
		@(posedge CLK) disable iff (SRST)
		sp_mode && !run_now && ext_rise |=> run_now && s_ff.pulse;
	endproperty
	a_ext_trigger: assert property (p_ext_trigger) else $error("pin edge did not start pulse");

	property p_match_stop;
		@(posedge CLK) disable iff (SRST)
		match_a && !start |=> !run_now && !s_ff.pulse && s_ff.match_a_flag && $stable(s_ff.cnt);
	endproperty
	a_match_stop: assert property (p_match_stop) else $error("match A did not end pulse");

	property p_no_period_sp;
		@(posedge CLK) disable iff (SRST)
		sp_mode && !s_ff.period_match_flag |=> !s_ff.period_match_flag;
	endproperty
	a_no_period_sp: assert property (p_no_period_sp) else $error("period flag in single pulse");

	property p_cap_flag;
		@(posedge CLK) disable iff (SRST)
		cap_fire |=> (s_ff.compare_a_value == $past(s_ff.cnt) || s_ff.compare_b_value == $past(s_ff.cnt))
			##1 s_ff.match_a_flag;
	endproperty
	a_cap_flag: assert property (p_cap_flag) else $error("capture latch or flag late");

	property p_no_capture;
		@(posedge CLK) disable iff (SRST)
		cp_mode && s_ff.io_select == sp_cap_pkg::IO_NONE && !do_wr |=> $stable(s_ff.compare_a_value)
			&& $stable(s_ff.compare_b_value);
	endproperty
	a_no_capture: assert property (p_no_capture) else $error("capture with edges disabled");

	property p_free_run;
		@(posedge CLK) disable iff (SRST)
		cp_mode && run_now && !per_hit && !clr_edge && !do_wr |=> s_ff.cnt == $past(cnt_inc);
	endproperty
	a_free_run: assert property (p_free_run) else $error("capture counter stalled");

	property p_period_clear;
		@(posedge CLK) disable iff (SRST)
		cp_mode && run_now && per_hit && !do_wr |=> s_ff.cnt == '0 && s_ff.period_match_flag;
	endproperty
	a_period_clear: assert property (p_period_clear) else $error("period match not handled");

	property p_pin_idle;
		@(posedge CLK) disable iff (SRST)
		cp_mode |-> PULSE_OE_N && !PULSE_OUT;
	endproperty
	a_pin_idle: assert property (p_pin_idle) else $error("pin driven in capture mode");

	property p_flag_hold;
		@(posedge CLK) disable iff (SRST)
		s_ff.match_a_flag && !(do_wr && s_ff.awaddr == sp_cap_pkg::STATUS_OFFS) |=> s_ff.match_a_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag A dropped on its own");
endmodule

// [tb/timer_single_pulse_capture_bench.sv]
// self-checking bench for the single-pulse / capture timer over AXI4-Lite
`timescale 1ns/100ps
module timer_single_pulse_capture_bench;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hF;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	logic        ext_pin = 1'b0;
	logic        cap_pin = 1'b0;
	logic        pulse_out;
	logic        pulse_oe_n;
	int          n_fail = 0;
	int          compares = 0;
	int          cycles = 0;
	logic [31:0] v1;
	logic [31:0] v2;
	int          w;

	sp_cap_timer u_sp_cap_timer (.CLK(clk), .SRST(srst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
		.BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready), .EXT_CLOCK_PIN(ext_pin), .CAPTURE_PIN(cap_pin),
		.PULSE_OUT(pulse_out), .PULSE_OE_N(pulse_oe_n));

	always #2.5 clk = ~clk;

	task automatic end_sim();
		$display("compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// bounded run time
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			$display("Error at %0t: run time limit reached", $time);
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 200);
		if (bvalid !== 1'b1) begin
			n_fail++;
			$display("Error at %0t: no write response", $time);
		end
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 200);
		if (rvalid !== 1'b1) begin
			n_fail++;
			$display("Error at %0t: no read response", $time);
		end
		d = rdata;
		rready <= 1'b0;
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d, sp_cap_pkg::RESP_OKAY);
		chk(d, e);
	endtask

	task automatic wok(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, sp_cap_pkg::RESP_OKAY);
	endtask

	function automatic logic [31:0] ctl(input logic [1:0] md, input logic [1:0] io, input logic run,
		input logic capts, input logic [1:0] tclr, input logic oc, input logic pol);
		logic [31:0] c;
		c = 32'h0;
		c[sp_cap_pkg::MODE_LSB +: 2] = md;
		c[sp_cap_pkg::IO_LSB +: 2] = io;
		c[sp_cap_pkg::RUN_BIT] = run;
		c[sp_cap_pkg::CAPTS_BIT] = capts;
		c[sp_cap_pkg::TCLR_LSB +: 2] = tclr;
		c[sp_cap_pkg::CCLR_BIT] = 1'b1;
		c[sp_cap_pkg::OC_BIT] = oc;
		c[sp_cap_pkg::POL_BIT] = pol;
		return c;
	endfunction

	// drive one pin high for wd cycles, then let the synchroniser settle
	task automatic pin_pulse(input logic use_ext, input int wd);
		@(posedge clk);
		if (use_ext)
			ext_pin <= 1'b1;
		else
			cap_pin <= 1'b1;
		repeat (wd) @(posedge clk);
		ext_pin <= 1'b0;
		cap_pin <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	// cycles during which the output sits at lvl
	task automatic pw(input logic lvl, output int wd);
		int n;
		n = 0;
		wd = 0;
		while (pulse_out !== lvl && n < 60) begin
			@(posedge clk);
			n++;
		end
		while (pulse_out === lvl && wd < 3000) begin
			@(posedge clk);
			wd++;
		end
	endtask

	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rchk(sp_cap_pkg::CTRL_OFFS, 32'h0);
		rchk(sp_cap_pkg::STATUS_OFFS, 32'h0);
		rchk(sp_cap_pkg::COUNT_OFFS, 32'h0);
		rd(8'h18, v1, sp_cap_pkg::RESP_SLVERR);
		chk(v1, 32'h0);
		wr(8'h1C, 32'h5, sp_cap_pkg::RESP_SLVERR);
		chk({31'h0, pulse_oe_n}, 32'h1);
		$display("test reset_and_map done");

		for (int p = 1; p >= 0; p--) begin
			wok(sp_cap_pkg::CMPA_OFFS, 32'hA);
			wok(sp_cap_pkg::PERIOD_OFFS, 32'h3);
			wok(sp_cap_pkg::CTRL_OFFS, ctl(sp_cap_pkg::MODE_SINGLE, sp_cap_pkg::IO_NONE, 1'b1, 1'b0, 2'h0, 1'b1, p[0]));
			chk({31'h0, pulse_oe_n}, 32'h0);
			pw(~p[0], w);
			chk(w, 32'hB);
			chk({31'h0, pulse_out}, {31'h0, p[0]});
			rchk(sp_cap_pkg::STATUS_OFFS, 32'h1);
			rchk(sp_cap_pkg::COUNT_OFFS, 32'hA);
			rchk(sp_cap_pkg::CTRL_OFFS, ctl(sp_cap_pkg::MODE_SINGLE, sp_cap_pkg::IO_NONE, 1'b0, 1'b0, 2'h0, 1'b1, p[0]));
			repeat (20) @(posedge clk);
			rchk(sp_cap_pkg::STATUS_OFFS, 32'h1);
			wok(sp_cap_pkg::STATUS_OFFS, 32'h3);
			rchk(sp_cap_pkg::STATUS_OFFS, 32'h0);
		end
		$display("test single_pulse_software done");

		fork
			pin_pulse(1'b1, 4);
			pw(1'b1, w);
		join
		chk(w, 32'hB);
		rchk(sp_cap_pkg::STATUS_OFFS, 32'h1);
		wok(sp_cap_pkg::STATUS_OFFS, 32'h1);
		$display("test single_pulse_pin_trigger done");

		wok(sp_cap_pkg::CMPA_OFFS, 32'h3E8);
		wok(sp_cap_pkg::CTRL_OFFS, ctl(sp_cap_pkg::MODE_SINGLE, sp_cap_pkg::IO_NONE, 1'b1, 1'b0, 2'h0, 1'b1, 1'b0));
		repeat (20) @(posedge clk);
		chk({31'h0, pulse_out}, 32'h1);
		wok(sp_cap_pkg::CTRL_OFFS, ctl(sp_cap_pkg::MODE_SINGLE, sp_cap_pkg::IO_NONE, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0));
		repeat (3) @(posedge clk);
		chk({31'h0, pulse_out}, 32'h0);
		rchk(sp_cap_pkg::STATUS_OFFS, 32'h0);
		rd(sp_cap_pkg::COUNT_OFFS, v1, sp_cap_pkg::RESP_OKAY);
		rchk(sp_cap_pkg::COUNT_OFFS, v1);
		$display("test single_pulse_abort done");

		wok(sp_cap_pkg::PERIOD_OFFS, 32'h0);
		wok(sp_cap_pkg::CMPA_OFFS, 32'h1234);
		wok(sp_cap_pkg::CTRL_OFFS, ctl(sp_cap_pkg::MODE_CAPTURE, sp_cap_pkg::IO_NONE, 1'b1, 1'b0, 2'h0, 1'b1, 1'b1));
		pin_pulse(1'b0, 10);
		rchk(sp_cap_pkg::CMPA_OFFS, 32'h1234);
		rchk(sp_cap_pkg::STATUS_OFFS, 32'h0);
		rd(sp_cap_pkg::COUNT_OFFS, v1, sp_cap_pkg::RESP_OKAY);
		rd(sp_cap_pkg::COUNT_OFFS, v2, sp_cap_pkg::RESP_OKAY);
		chk({31'h0, v1 !== v2}, 32'h1);
		chk({30'h0, pulse_oe_n, pulse_out}, 32'h2);
		wok(sp_cap_pkg::CTRL_OFFS, ctl(sp_cap_pkg::MODE_CAPTURE, sp_cap_pkg::IO_BOTH, 1'b1, 1'b0,
			sp_cap_pkg::TCLR_RISE, 1'b1, 1'b1));
		pin_pulse(1'b0, 50);
		rchk(sp_cap_pkg::CMPA_OFFS, 32'h31);
		rd(sp_cap_pkg::CMPB_OFFS, v1, sp_cap_pkg::RESP_OKAY);
		chk({31'h0, v1 !== 32'h0}, 32'h1);
		rchk(sp_cap_pkg::STATUS_OFFS, 32'h1);
		$display("test capture_edges done");

		wok(sp_cap_pkg::STATUS_OFFS, 32'h3);
		wok(sp_cap_pkg::CMPA_OFFS, 32'h1234);
		wok(sp_cap_pkg::CTRL_OFFS, ctl(sp_cap_pkg::MODE_CAPTURE, sp_cap_pkg::IO_RISE, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0));
		pin_pulse(1'b0, 10);
		rchk(sp_cap_pkg::CMPA_OFFS, 32'h1234);
		pin_pulse(1'b1, 10);
		rchk(sp_cap_pkg::STATUS_OFFS, 32'h1);
		rd(sp_cap_pkg::CMPA_OFFS, v1, sp_cap_pkg::RESP_OKAY);
		chk({31'h0, v1 !== 32'h1234}, 32'h1);
		$display("test capture_source done");

		wok(sp_cap_pkg::CMPA_OFFS, 32'h1234);
		wok(sp_cap_pkg::CTRL_OFFS, ctl(sp_cap_pkg::MODE_CAPTURE, sp_cap_pkg::IO_FALL, 1'b1, 1'b0,
			sp_cap_pkg::TCLR_FALL, 1'b0, 1'b0));
		pin_pulse(1'b0, 10);
		pin_pulse(1'b0, 10);
		rchk(sp_cap_pkg::CMPB_OFFS, 32'h12);
		rchk(sp_cap_pkg::CMPA_OFFS, 32'h1234);
		wok(sp_cap_pkg::CTRL_OFFS, ctl(sp_cap_pkg::MODE_CAPTURE, sp_cap_pkg::IO_BOTH, 1'b1, 1'b0, 2'h3, 1'b0, 1'b0));
		pin_pulse(1'b0, 20);
		rchk(sp_cap_pkg::CMPB_OFFS, 32'h13);
		rchk(sp_cap_pkg::CMPA_OFFS, 32'h1234);
		$display("test capture_clear_edges done");

		wok(sp_cap_pkg::CTRL_OFFS, ctl(sp_cap_pkg::MODE_CAPTURE, sp_cap_pkg::IO_NONE, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
		wok(sp_cap_pkg::PERIOD_OFFS, 32'h14);
		wok(sp_cap_pkg::STATUS_OFFS, 32'h3);
		wok(sp_cap_pkg::CTRL_OFFS, ctl(sp_cap_pkg::MODE_CAPTURE, sp_cap_pkg::IO_NONE, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0));
		repeat (60) @(posedge clk);
		rchk(sp_cap_pkg::STATUS_OFFS, 32'h2);
		rd(sp_cap_pkg::COUNT_OFFS, v1, sp_cap_pkg::RESP_OKAY);
		chk({31'h0, v1 <= 32'h14}, 32'h1);
		wok(sp_cap_pkg::CTRL_OFFS, ctl(sp_cap_pkg::MODE_CAPTURE, sp_cap_pkg::IO_NONE, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
		rd(sp_cap_pkg::COUNT_OFFS, v1, sp_cap_pkg::RESP_OKAY);
		rchk(sp_cap_pkg::COUNT_OFFS, v1);
		$display("test capture_period done");
		end_sim();
	end
endmodule
